/* rtl/dlas_pkg.sv */
// Constants of the two-channel linked scan sequencer: register map, fields, reset values, states.
// Assumes a 32-bit AXI4-Lite slave and a byte-addressed memory port on the same clock.
package dlas_pkg;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CNT_W = 9;
  // Register index inside a channel window, byte address bits [4:2].
  localparam logic [2:0] REG_SRC = 3'h0;
  localparam logic [2:0] REG_DST = 3'h1;
  localparam logic [2:0] REG_OFF = 3'h2;
  localparam logic [2:0] REG_SLAST = 3'h3;
  localparam logic [2:0] REG_DLAST = 3'h4;
  localparam logic [2:0] REG_NBYTES = 3'h5;
  localparam logic [2:0] REG_ITER = 3'h6;
  localparam logic [2:0] REG_CSR = 3'h7;
  localparam int unsigned CH_SEL_BIT = 5;
  localparam logic [7:0] MAP_END = 8'h40;
  // Iteration word: beginning count low, current count high.
  localparam int unsigned ITER_LINKCH_BIT = 9;
  localparam int unsigned ITER_ELINK_BIT = 15;
  localparam int unsigned CITER_LSB = 16;
  // Control and status word.
  localparam int unsigned CSR_START = 0;
  localparam int unsigned CSR_INTMAJ = 1;
  localparam int unsigned CSR_INTHALF = 2;
  localparam int unsigned CSR_WIDE = 3;
  localparam int unsigned CSR_MAJELINK = 5;
  localparam int unsigned CSR_DONE = 6;
  localparam int unsigned CSR_ACTIVE = 7;
  localparam int unsigned CSR_MAJLINKCH = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD = 4'b0010,
    ST_WR = 4'b0100,
    ST_END = 4'b1000
  } dlas_state_e;
endpackage : dlas_pkg

/* rtl/dlas_seq.sv */
// Two-channel DMA engine with minor and major loop linking, driving a converter scan.
// Assumes requests, memory port and register bus all run on aclk.
// Behaviour
// - Each accepted request runs exactly one minor loop on its channel.
// - Minor loop length counts bytes; a 16-bit datum uses two.
// - Major loop is many minor loops, then addresses adjust for circular buffers.
// - Major loop completion pulses an interrupt request when enabled.
// - Half of the major iterations pulses an optional interrupt request.
// - Enabled linking starts the linked channel without external request.
// - Minor and major link enables and targets are separate per channel.
// - Channel 1, higher priority, moves results into the SRAM buffer.
// - Channel 0, lower priority, moves next input setting to converter control.
// - Channel 1 minor link starts channel 0 after each stored result except the last of a major loop.
// - Result is read before next setting is written, by fixed priority.
// - Single scan uses only minor linking via the iteration count words.
// - Continuous scan adds major linking in the control and status word.
// - The final iteration issues only the major link, never the minor.
// - Example major loop writes twelve entries into a larger buffer.
// - After a major loop the result pointer returns to buffer start.
// - Result destination steps two bytes, rewinds by twenty-four after major.
// - Result channel major completion links channel 0 and interrupts.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
module dlas_seq
  import dlas_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Hardware request strobes, one per channel
  input wire logic [NUM_CH-1:0] dma_req,
  // Memory master port
  output logic mem_valid,
  output logic mem_we,
  output logic mem_wide,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  // Interrupt request pulses
  output logic [NUM_CH-1:0] irq_major,
  output logic [NUM_CH-1:0] irq_half
);
  logic [31:0] src_r [NUM_CH], src_nxt [NUM_CH];
  logic [31:0] dst_r [NUM_CH], dst_nxt [NUM_CH];
  logic [31:0] off_r [NUM_CH], off_nxt [NUM_CH];
  logic [31:0] slast_r [NUM_CH], slast_nxt [NUM_CH];
  logic [31:0] dlast_r [NUM_CH], dlast_nxt [NUM_CH];
  logic [31:0] nby_r [NUM_CH], nby_nxt [NUM_CH];
  logic [31:0] iter_r [NUM_CH], iter_nxt [NUM_CH];
  logic [31:0] csr_r [NUM_CH], csr_nxt [NUM_CH];
  logic [NUM_CH-1:0] pend_r, pend_nxt, sw_start, link_set;
  dlas_state_e st_r, st_nxt;
  logic sel_r, sel_nxt;
  logic [31:0] left_r, left_nxt, maddr_r, maddr_nxt;
  logic [15:0] data_r, data_nxt;
  logic wide_r, wide_nxt;
  logic [NUM_CH-1:0] irqm_r, irqm_nxt, irqh_r, irqh_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [CNT_W-1:0] cit_dec, biter;
  logic maj_end;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a < MAP_END);
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  assign s_axi_awready = ce && !aw_ok_r && !bvalid_r;
  assign s_axi_wready = ce && !w_ok_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign mem_valid = ce && (st_r == ST_RD || st_r == ST_WR);
  assign mem_we = (st_r == ST_WR);
  assign mem_wide = wide_r;
  assign mem_addr = maddr_r;
  assign mem_wdata = data_r;
  assign irq_major = irqm_r;
  assign irq_half = irqh_r;
  assign cit_dec = iter_r[sel_r][CITER_LSB +: CNT_W] - 9'h001;
  assign biter = iter_r[sel_r][CNT_W-1:0];
  assign maj_end = (st_r == ST_END) && (cit_dec == 9'h000);

  always_comb begin
    logic ch;
    logic [2:0] ri;
    ch = 1'b0;
    ri = 3'h0;
    src_nxt = src_r;
    dst_nxt = dst_r;
    off_nxt = off_r;
    slast_nxt = slast_r;
    dlast_nxt = dlast_r;
    nby_nxt = nby_r;
    iter_nxt = iter_r;
    csr_nxt = csr_r;
    sw_start = '0;
    link_set = '0;
    st_nxt = st_r;
    sel_nxt = sel_r;
    left_nxt = left_r;
    maddr_nxt = maddr_r;
    data_nxt = data_r;
    wide_nxt = wide_r;
    irqm_nxt = '0;
    irqh_nxt = '0;
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    // Write channel: address and data are caught in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_ok_r && w_ok_r && !bvalid_r) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      ch = awaddr_r[CH_SEL_BIT];
      ri = awaddr_r[4:2];
      if (addr_ok(awaddr_r)) begin
        unique case (ri)
          REG_SRC: src_nxt[ch] = merge(src_r[ch], wdata_r, wstrb_r);
          REG_DST: dst_nxt[ch] = merge(dst_r[ch], wdata_r, wstrb_r);
          REG_OFF: off_nxt[ch] = merge(off_r[ch], wdata_r, wstrb_r);
          REG_SLAST: slast_nxt[ch] = merge(slast_r[ch], wdata_r, wstrb_r);
          REG_DLAST: dlast_nxt[ch] = merge(dlast_r[ch], wdata_r, wstrb_r);
          REG_NBYTES: nby_nxt[ch] = merge(nby_r[ch], wdata_r, wstrb_r);
          REG_ITER: begin
            iter_nxt[ch][15:0] = 16'(merge(iter_r[ch], wdata_r, wstrb_r) & 32'h0000_83FF);
            iter_nxt[ch][31:16] = {7'h00, iter_nxt[ch][CNT_W-1:0]};
          end
          REG_CSR: begin
            csr_nxt[ch] = (merge(csr_r[ch], wdata_r, wstrb_r) & 32'h0000_013E) | (csr_r[ch] & 32'h0000_00C0);
            if (wstrb_r[0] && wdata_r[CSR_DONE]) begin
              csr_nxt[ch][CSR_DONE] = 1'b0;
            end
            sw_start[ch] = wstrb_r[0] && wdata_r[CSR_START];
          end
        endcase
      end
    end
    // Read channel: one word answered on the cycle after the address.
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      ch = s_axi_araddr[CH_SEL_BIT];
      rdata_nxt = RST_WORD;
      if (addr_ok(s_axi_araddr)) begin
        unique case (s_axi_araddr[4:2])
          REG_SRC: rdata_nxt = src_r[ch];
          REG_DST: rdata_nxt = dst_r[ch];
          REG_OFF: rdata_nxt = off_r[ch];
          REG_SLAST: rdata_nxt = slast_r[ch];
          REG_DLAST: rdata_nxt = dlast_r[ch];
          REG_NBYTES: rdata_nxt = nby_r[ch];
          REG_ITER: rdata_nxt = iter_r[ch];
          REG_CSR: rdata_nxt = csr_r[ch];
        endcase
      end
    end
    // Transfer engine.
    unique case (st_r)
      ST_IDLE: begin
        if (pend_r != '0) begin
          sel_nxt = pend_r[1];
          left_nxt = nby_r[sel_nxt];
          maddr_nxt = src_r[sel_nxt];
          wide_nxt = csr_r[sel_nxt][CSR_WIDE];
          csr_nxt[sel_nxt][CSR_ACTIVE] = 1'b1;
          st_nxt = ST_RD;
        end
      end
      ST_RD: begin
        if (mem_ready) begin
          data_nxt = mem_rdata;
          src_nxt[sel_r] = src_r[sel_r] + {{16{off_r[sel_r][15]}}, off_r[sel_r][15:0]};
          maddr_nxt = dst_r[sel_r];
          st_nxt = ST_WR;
        end
      end
      ST_WR: begin
        if (mem_ready) begin
          dst_nxt[sel_r] = dst_r[sel_r] + {{16{off_r[sel_r][31]}}, off_r[sel_r][31:16]};
          left_nxt = left_r - (wide_r ? 32'h0000_0002 : 32'h0000_0001);
          maddr_nxt = src_r[sel_r];
          st_nxt = (left_r <= (wide_r ? 32'h0000_0002 : 32'h0000_0001)) ? ST_END : ST_RD;
        end
      end
      ST_END: begin
        st_nxt = ST_IDLE;
        csr_nxt[sel_r][CSR_ACTIVE] = 1'b0;
        iter_nxt[sel_r][CITER_LSB +: CNT_W] = cit_dec;
        irqh_nxt[sel_r] = csr_r[sel_r][CSR_INTHALF] && (biter[CNT_W-1:1] != 8'h00) && (cit_dec == {1'b0, biter[CNT_W-1:1]});
        if (maj_end) begin
          iter_nxt[sel_r][CITER_LSB +: CNT_W] = biter;
          src_nxt[sel_r] = src_r[sel_r] + slast_r[sel_r];
          dst_nxt[sel_r] = dst_r[sel_r] + dlast_r[sel_r];
          csr_nxt[sel_r][CSR_DONE] = 1'b1;
          irqm_nxt[sel_r] = csr_r[sel_r][CSR_INTMAJ];
          link_set[csr_r[sel_r][CSR_MAJLINKCH]] = csr_r[sel_r][CSR_MAJELINK];
        end else begin
          link_set[iter_r[sel_r][ITER_LINKCH_BIT]] = iter_r[sel_r][ITER_ELINK_BIT];
        end
      end
    endcase
  end

  // Pending requests: a new request in the take cycle is kept.
  logic [NUM_CH-1:0] take;
  function automatic logic [NUM_CH-1:0] pend_nxt_clear(input logic c);
    pend_nxt_clear = '0;
    pend_nxt_clear[c] = 1'b1;
  endfunction : pend_nxt_clear
  assign take = (st_r == ST_IDLE && pend_r != '0) ? pend_nxt_clear(pend_r[1]) : '0;
  assign pend_nxt = (pend_r & ~take) | dma_req | sw_start | link_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        src_r[i] <= RST_WORD;
        dst_r[i] <= RST_WORD;
        off_r[i] <= RST_WORD;
        slast_r[i] <= RST_WORD;
        dlast_r[i] <= RST_WORD;
        nby_r[i] <= RST_WORD;
        iter_r[i] <= RST_WORD;
        csr_r[i] <= RST_WORD;
      end
      pend_r <= '0;
      st_r <= ST_IDLE;
      sel_r <= 1'b0;
      left_r <= RST_WORD;
      maddr_r <= RST_WORD;
      data_r <= 16'h0000;
      wide_r <= 1'b0;
      irqm_r <= '0;
      irqh_r <= '0;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= RST_WORD;
      wstrb_r <= 4'h0;
      rdata_r <= RST_WORD;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      off_r <= off_nxt;
      slast_r <= slast_nxt;
      dlast_r <= dlast_nxt;
      nby_r <= nby_nxt;
      iter_r <= iter_nxt;
      csr_r <= csr_nxt;
      pend_r <= pend_nxt;
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      left_r <= left_nxt;
      maddr_r <= maddr_nxt;
      data_r <= data_nxt;
      wide_r <= wide_nxt;
      irqm_r <= irqm_nxt;
      irqh_r <= irqh_nxt;
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      rdata_r <= rdata_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  sequence s_rd_done;
    ce && st_r == ST_RD && mem_ready;
  endsequence
  sequence s_wr_step;
    st_r == ST_WR && mem_we && mem_addr == $past(dst_r[sel_r]);
  endsequence
  property p_launch;
    @(posedge aclk) disable iff (!aresetn) ce && st_r == ST_IDLE && pend_r != '0 |=> st_r == ST_RD && sel_r == $past(pend_r[1]);
  endproperty
  a_launch: assert property (p_launch) else $error("request did not start a minor loop");
  property p_rd_then_wr;
    @(posedge aclk) disable iff (!aresetn) s_rd_done |=> s_wr_step;
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("write did not follow read");
  property p_bytes;
    @(posedge aclk) disable iff (!aresetn) ce && st_r == ST_WR && mem_ready && left_r == 32'h0000_0002 && wide_r
      |=> st_r == ST_END;
  endproperty
  a_bytes: assert property (p_bytes) else $error("minor loop length wrong");
  property p_prio;
    @(posedge aclk) disable iff (!aresetn) ce && st_r == ST_IDLE && pend_r == 2'b11 |=> sel_r && st_r == ST_RD;
  endproperty
  a_prio: assert property (p_prio) else $error("channel 0 served before channel 1");
  property p_reload;
    @(posedge aclk) disable iff (!aresetn) ce && maj_end |=> iter_r[$past(sel_r)][CITER_LSB +: CNT_W] == $past(biter);
  endproperty
  a_reload: assert property (p_reload) else $error("current count not reloaded");
  property p_rewind;
    @(posedge aclk) disable iff (!aresetn) ce && maj_end |=> dst_r[sel_r] == $past(dst_r[sel_r]) + $past(dlast_r[sel_r]);
  endproperty
  a_rewind: assert property (p_rewind) else $error("destination not rewound");
  property p_irq_major;
    @(posedge aclk) disable iff (!aresetn) ce && maj_end && csr_r[sel_r][CSR_INTMAJ] |=> irq_major[sel_r] ##1 !irq_major[sel_r];
  endproperty
  a_irq_major: assert property (p_irq_major) else $error("major interrupt pulse missing");
  property p_minor_link;
    @(posedge aclk) disable iff (!aresetn) ce && st_r == ST_END && !maj_end && iter_r[sel_r][ITER_ELINK_BIT]
      |=> pend_r[$past(iter_r[sel_r][ITER_LINKCH_BIT])] || st_r == ST_RD;
  endproperty
  a_minor_link: assert property (p_minor_link) else $error("minor link request missing");
  property p_last_no_minor;
    @(posedge aclk) disable iff (!aresetn) maj_end && !csr_r[sel_r][CSR_MAJELINK] |-> link_set == '0;
  endproperty
  a_last_no_minor: assert property (p_last_no_minor) else $error("minor link fired on final iteration");
  property p_half;
    @(posedge aclk) disable iff (!aresetn) irq_half != '0 |-> $past(st_r) == ST_END && $past(csr_r[sel_r][CSR_INTHALF]);
  endproperty
  a_half: assert property (p_half) else $error("half interrupt without cause");
endmodule : dlas_seq

/* bench/dlas_mem_model.sv */
// Far-side model: byte memory holding the converter registers, the result buffer and the setting table.
// Assumes one access at a time on the engine memory port, finished by a one-cycle ready.
module dlas_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory port from the engine
  input wire logic mem_valid,
  input wire logic mem_we,
  input wire logic mem_wide,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ready,
  output logic [15:0] mem_rdata,
  // Random wait states when high
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [31:0]];
  logic [48:0] log_q [$];
  logic [7:0] lfsr = 8'h5A;

  function automatic logic [7:0] rd8(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd8

  // Read data toggles while no answer stands, so stale data never looks valid.
  always @(posedge aclk) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    mem_ready <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      mem_rdata <= 16'h0000;
    end else if (mem_valid && mem_ready) begin
      log_q.push_back({mem_we, mem_we ? mem_wdata : mem_rdata, mem_addr});
      if (mem_we) begin
        mem[mem_addr] = mem_wdata[7:0];
        if (mem_wide) begin
          mem[mem_addr + 32'h0000_0001] = mem_wdata[15:8];
        end
      end
    end else if (mem_valid && (!slow || lfsr[0])) begin
      mem_ready <= 1'b1;
      mem_rdata <= {mem_wide ? rd8(mem_addr + 32'h0000_0001) : 8'h00, rd8(mem_addr)};
    end
  end
endmodule : dlas_mem_model

/* bench/dlas_seq_tb.sv */
// Self-checking bench for the linked scan sequencer: configures both channels and runs random scans.
// Assumes the far-side memory model answers the memory port and holds the converter registers.
module dlas_seq_tb;
  import dlas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] RES = 32'h4000_0010;
  localparam logic [31:0] CTL = 32'h4000_0000;
  localparam logic [31:0] BUF = 32'h2000_0000;
  localparam logic [31:0] TAB = 32'h0000_1000;
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [1:0] dma_req = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_major, irq_half;
  logic [31:0] s_axi_rdata, mem_addr;
  logic mem_valid, mem_we, mem_wide, mem_ready;
  logic [15:0] mem_wdata, mem_rdata;
  logic [31:0] seed = 32'h0000_AB75;
  int bad_count = 0, num_checks = 0, cyc = 0, n_maj = 0, n_half = 0, n_irq0 = 0, t = 0;
  logic [31:0] cfg1 [8] = '{RES, BUF, 32'h0002_0000, 32'h0, 32'hFFFF_FFE8, 32'h2, 32'h800C, 32'h2E};
  logic [31:0] cfg0 [8] = '{TAB, CTL, 32'h1, 32'hFFFF_FFFD, 32'h0, 32'h1, 32'h3, 32'h0};

  dlas_seq DUT (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dma_req, .mem_valid, .mem_we, .mem_wide, .mem_addr, .mem_wdata, .mem_ready,
    .mem_rdata, .irq_major, .irq_half);
  dlas_mem_model PART (.aclk, .aresetn, .mem_valid, .mem_we, .mem_wide, .mem_addr, .mem_wdata,
    .mem_ready, .mem_rdata, .slow);

  always #25 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    n_maj <= n_maj + int'(irq_major[1] === 1'b1);
    n_half <= n_half + int'(irq_half[1] === 1'b1);
    n_irq0 <= n_irq0 + (aresetn ? int'(irq_major[0] !== 1'b0) + int'(irq_half[0] !== 1'b0) : 0);
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] ra(input int ch, input logic [2:0] idx);
    return 8'(ch * 32 + int'(idx) * 4);
  endfunction : ra

  function automatic logic [7:0] tab_val(input int i);
    return 8'(8'h05 + 7 * (i % 3));
  endfunction : tab_val

  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    chk({tb, rs}, {1'b1, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ta, tr;
    logic [33:0] rd;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      rd = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    chk({tr, rd}, {1'b1, er, exp});
  endtask : axi_rd

  // One conversion: result request, optional direct setting request, then the logged accesses.
  task automatic conv(input int k, input logic both, input logic link);
    logic [15:0] v;
    logic [48:0] e [$];
    int n;
    v = 16'(rnd());
    PART.mem[RES] = v[7:0];
    PART.mem[RES + 32'h0000_0001] = v[15:8];
    PART.log_q.delete();
    @(posedge aclk);
    slow <= v[15];
    dma_req <= {1'b1, both};
    @(posedge aclk);
    dma_req <= 2'h0;
    e = '{{1'b0, v, RES}, {1'b1, v, BUF + 32'(2 * (k % 12))}};
    if (link || both) begin
      e.push_back({1'b0, 8'h00, tab_val(t), TAB + 32'(t % 3)});
      e.push_back({1'b1, 8'h00, tab_val(t), CTL});
      t = t + 1;
    end
    n = 0;
    while (PART.log_q.size() < e.size() && n < 300) begin
      @(posedge aclk);
      n++;
    end
    repeat (16) @(posedge aclk);
    chk(49'(PART.log_q.size()), 49'(e.size()));
    foreach (e[i]) chk(PART.log_q[i], e[i]);
    axi_rd(ra(1, REG_ITER), {7'h00, 9'(12 - (k + 1) % 12), 16'h800C}, RESP_OKAY);
  endtask : conv

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) PART.mem[TAB + 32'(i)] = tab_val(i);
    chk({irq_major, irq_half, mem_valid}, 5'h00);
    for (int i = 0; i < 8; i++) begin
      axi_wr(ra(1, 3'(i)), cfg1[i], RESP_OKAY);
      axi_wr(ra(0, 3'(i)), cfg0[i], RESP_OKAY);
    end
    axi_rd(ra(1, REG_DST), BUF, RESP_OKAY);
    axi_rd(ra(1, REG_CSR), 32'h0000_002E, RESP_OKAY);
    axi_wr(MAP_END, 32'h0000_0001, RESP_SLVERR);
    axi_rd(MAP_END + 8'h04, 32'h0000_0000, RESP_SLVERR);
    for (int k = 0; k < 36; k++) begin
      // Major linking is dropped after the first scan, leaving single-scan minor linking only.
      if (k == 12) axi_wr(ra(1, REG_CSR), 32'h0000_000E, RESP_OKAY);
      conv(k, k == 23, k != 35);
    end
    chk(49'(n_maj), 49'h3);
    chk(49'(n_half), 49'h3);
    chk(49'(n_irq0), 49'h0);
    chk(49'(PART.mem.exists(BUF + 32'h0000_0018)), 49'h0);
    axi_rd(ra(1, REG_DST), BUF, RESP_OKAY);
    test_done();
  end
endmodule : dlas_seq_tb
